//--- logic/adsq_core.sv
`timescale 1ns/1ps
`default_nettype none
`include "adsq_map.svh"
module adsq_core (
   input  wire logic                 core_clk,
   input  wire logic                 reset,
   input  wire logic [2:0]           reg_addr,
   input  wire logic [7:0]           reg_wdata,
   input  wire logic                 reg_wr,
   input  wire logic                 reg_rd,
   output logic      [7:0]           reg_rdata,
   input  wire logic                 rc_tick,
   input  wire logic                 comp_in,
   output logic      [3:0]           sample_channel,
   output logic                      sample_switch_closed,
   output logic                      low_ref_from_pin,
   output logic                      high_ref_from_pin,
   output logic      [12:0]          pin_analog_en,
   output logic      [9:0]           dac_code,
   output logic                      converter_irq_flag,
   output logic                      converter_irq
);
   import adsq_pkg::*;

   // software-visible registers
   logic        converter_power_on_r;
   logic        go_r;
   logic [3:0]  channel_select_r;
   logic [7:0]  port_cfg_r;
   logic [7:0]  timing_r;
   logic [7:0]  res_hi_r;
   logic [7:0]  res_lo_r;
   logic        irq_flag_r;
   logic        irq_en_r;
   logic [7:0]  reg_rdata_r;

   // sequencer state and phase counters
   adsq_state_t state_r;
   adsq_state_t state_nxt;
   logic [4:0]  tad_cnt_r;
   logic [1:0]  dly_cnt_r;
   logic        wait_extra_r;

   // approximation datapath
   logic [9:0]  sar_r;
   logic [9:0]  trial_r;

   // decoded strobes and events
   logic [4:0]  acq_tads;
   logic        tick;
   logic        tad_run;
   logic        wr_main;
   logic        wr_port;
   logic        wr_timing;
   logic        wr_res_hi;
   logic        wr_res_lo;
   logic        wr_flags;
   logic        done_evt;
   logic        abort_evt;
   logic [15:0] result_word;

   // index decode; unmapped indices match none of these
   assign wr_main   = reg_wr && reg_addr == `ADSQ_OFS_MAIN;
   assign wr_port   = reg_wr && reg_addr == `ADSQ_OFS_PORT;
   assign wr_timing = reg_wr && reg_addr == `ADSQ_OFS_TIMING;
   assign wr_res_hi = reg_wr && reg_addr == `ADSQ_OFS_RES_HI;
   assign wr_res_lo = reg_wr && reg_addr == `ADSQ_OFS_RES_LO;
   assign wr_flags  = reg_wr && reg_addr == `ADSQ_OFS_FLAGS;

   // divider runs in acquire, convert and wait; the delay phase is timed in clocks
   assign tad_run = state_r == ADSQ_ACQUIRE || state_r == ADSQ_CONVERT
                 || state_r == ADSQ_WAIT;

   adsq_tad_gen u_tad (
      .core_clk (core_clk),
      .reset    (reset),
      .run      (tad_run),
      .sel      (timing_r[2:0]),
      .rc_tick  (rc_tick),
      .tick     (tick)
   );

   // acquisition length in bit periods
   always_comb begin
      case (timing_r[`ADSQ_BIT_ACQ_LO +: 3])
         3'h7:    acq_tads = 5'd20;
         3'h6:    acq_tads = 5'd16;
         3'h5:    acq_tads = 5'd12;
         3'h4:    acq_tads = 5'd8;
         3'h3:    acq_tads = 5'd6;
         3'h2:    acq_tads = 5'd4;
         3'h1:    acq_tads = 5'd2;
         default: acq_tads = 5'd0;
      endcase
   end

   // conversion finishes on the last bit period
   assign done_evt  = state_r == ADSQ_CONVERT && tick
                   && tad_cnt_r == 5'(`ADSQ_CONV_TADS - 4'd1);
   // software dropping start or power mid-conversion aborts it
   assign abort_evt = (state_r == ADSQ_DELAY || state_r == ADSQ_ACQUIRE
                   || state_r == ADSQ_CONVERT)
                   && ((wr_main && !reg_wdata[`ADSQ_BIT_GO])
                   || !converter_power_on_r);

   // sequencer transitions
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         // start needs power; rc clock takes the sleep delay first
         ADSQ_SAMPLE: begin
            if (go_r && converter_power_on_r) begin
               if (timing_r[1:0] == 2'h3) begin
                  state_nxt = ADSQ_DELAY;
               end else if (acq_tads == 5'd0) begin
                  state_nxt = ADSQ_CONVERT;
               end else begin
                  state_nxt = ADSQ_ACQUIRE;
               end
            end
         end
         // one instruction cycle with the divider held
         ADSQ_DELAY: begin
            if (abort_evt) begin
               state_nxt = ADSQ_WAIT;
            end else if (dly_cnt_r == 2'(`ADSQ_TCY_CYC - 1)) begin
               state_nxt = (acq_tads == 5'd0) ? ADSQ_CONVERT : ADSQ_ACQUIRE;
            end
         end
         // programmed acquisition, switch still closed
         ADSQ_ACQUIRE: begin
            if (abort_evt) begin
               state_nxt = ADSQ_WAIT;
            end else if (tick && tad_cnt_r == acq_tads - 5'd1) begin
               state_nxt = ADSQ_CONVERT;
            end
         end
         // eleven periods; abort and completion both leave via the wait
         ADSQ_CONVERT: begin
            if (abort_evt || done_evt) begin
               state_nxt = ADSQ_WAIT;
            end
         end
         // post wait; after an abort the first tick is partial
         ADSQ_WAIT: begin
            if (tick && tad_cnt_r == 5'(`ADSQ_WAIT_TADS - 4'd1)
                                     + {4'd0, wait_extra_r}) begin
               state_nxt = ADSQ_SAMPLE;
            end
         end
         default: state_nxt = ADSQ_SAMPLE;
      endcase
   end

   // state register; reset drops any conversion
   always_ff @(posedge core_clk) begin
      if (reset) begin
         state_r <= ADSQ_SAMPLE;
      end else begin
         state_r <= state_nxt;
      end
   end

   // bit-period counter restarts on each phase change
   always_ff @(posedge core_clk) begin
      if (reset || state_nxt != state_r) begin
         tad_cnt_r <= 5'd0;
      end else if (tick) begin
         tad_cnt_r <= tad_cnt_r + 5'd1;
      end
   end

   // one instruction cycle of delay before the rc clock starts
   always_ff @(posedge core_clk) begin
      if (reset || state_r != ADSQ_DELAY) begin
         dly_cnt_r <= 2'd0;
      end else begin
         dly_cnt_r <= dly_cnt_r + 2'd1;
      end
   end

   // an abort lands mid-period, so one extra tick keeps two full periods
   always_ff @(posedge core_clk) begin
      if (reset || state_r == ADSQ_SAMPLE) begin
         wait_extra_r <= 1'b0;
      end else if (abort_evt) begin
         wait_extra_r <= 1'b1;
      end
   end

   // successive approximation, msb first, one bit per period
   always_ff @(posedge core_clk) begin
      if (reset || state_r != ADSQ_CONVERT) begin
         sar_r   <= 10'h000;
         trial_r <= 10'h200;
      end else if (tick && tad_cnt_r != 5'd0) begin
         // period 0 settles the dac; periods 1..10 decide bits
         sar_r   <= (sar_r | trial_r) & ~(comp_in ? 10'h000 : trial_r);
         trial_r <= trial_r >> 1;
      end
   end

   assign dac_code = sar_r | trial_r;

   // final bit is folded in as the result is stored
   logic [9:0] sar_final;
   assign sar_final   = (sar_r | trial_r) & ~(comp_in ? 10'h000 : trial_r);
   assign result_word = timing_r[`ADSQ_BIT_JUSTIFY]
                      ? {6'h00, sar_final}
                      : {sar_final, 6'h00};

   // power and channel select
   always_ff @(posedge core_clk) begin
      if (reset) begin
         converter_power_on_r <= 1'(`ADSQ_MAIN_RST >> `ADSQ_BIT_ON);
         channel_select_r     <= 4'h0;
      end else if (wr_main) begin
         converter_power_on_r <= reg_wdata[`ADSQ_BIT_ON];
         channel_select_r     <= reg_wdata[`ADSQ_BIT_CHS_LO +: 4];
      end
   end

   // start bit; a start in the same write as power-on is dropped on purpose,
   // so the analog front end has a cycle to come up before sampling is cut
   always_ff @(posedge core_clk) begin
      if (reset) begin
         go_r <= 1'b0;
      end else if (wr_main) begin
         go_r <= reg_wdata[`ADSQ_BIT_GO] && converter_power_on_r && !done_evt;
      end else if (done_evt || !converter_power_on_r) begin
         go_r <= 1'b0;
      end
   end

   // port configuration; bits 7:6 do not exist and read 0
   always_ff @(posedge core_clk) begin
      if (reset) begin
         port_cfg_r <= `ADSQ_PORT_RST;
      end else if (wr_port) begin
         port_cfg_r <= reg_wdata & 8'h3f;
      end
   end

   // timing and format; a change mid-conversion retimes the phase in flight
   always_ff @(posedge core_clk) begin
      if (reset) begin
         timing_r <= `ADSQ_TIMING_RST;
      end else if (wr_timing) begin
         timing_r <= reg_wdata & 8'hbf;
      end
   end

   // result high byte; aborted conversions leave it untouched
   always_ff @(posedge core_clk) begin
      if (reset) begin
         res_hi_r <= 8'h00;
      end else if (done_evt && !abort_evt) begin
         res_hi_r <= result_word[15:8];
      end else if (wr_res_hi) begin
         res_hi_r <= reg_wdata;
      end
   end

   // result low byte; completion beats a software write
   always_ff @(posedge core_clk) begin
      if (reset) begin
         res_lo_r <= 8'h00;
      end else if (done_evt && !abort_evt) begin
         res_lo_r <= result_word[7:0];
      end else if (wr_res_lo) begin
         res_lo_r <= reg_wdata;
      end
   end

   // flag: completion wins over a software clear in the same cycle
   always_ff @(posedge core_clk) begin
      if (reset) begin
         irq_flag_r <= 1'b0;
      end else if (done_evt && !abort_evt) begin
         irq_flag_r <= 1'b1;
      end else if (wr_flags) begin
         irq_flag_r <= reg_wdata[`ADSQ_BIT_IRQF];
      end
   end

   // interrupt enable; the request output is just flag and enable
   always_ff @(posedge core_clk) begin
      if (reset) begin
         irq_en_r <= 1'b0;
      end else if (wr_flags) begin
         irq_en_r <= reg_wdata[`ADSQ_BIT_IRQE];
      end
   end

   // read data one cycle after the strobe
   always_ff @(posedge core_clk) begin
      if (reset) begin
         reg_rdata_r <= 8'h00;
      end else if (reg_rd) begin
         case (reg_addr)
            `ADSQ_OFS_MAIN:   reg_rdata_r <= {2'h0, channel_select_r, go_r,
                                              converter_power_on_r};
            `ADSQ_OFS_PORT:   reg_rdata_r <= port_cfg_r;
            `ADSQ_OFS_TIMING: reg_rdata_r <= timing_r;
            `ADSQ_OFS_RES_HI: reg_rdata_r <= res_hi_r;
            `ADSQ_OFS_RES_LO: reg_rdata_r <= res_lo_r;
            `ADSQ_OFS_FLAGS:  reg_rdata_r <= {6'h00, irq_en_r, irq_flag_r};
            default:          reg_rdata_r <= 8'h00;
         endcase
      end else begin
         reg_rdata_r <= 8'h00;
      end
   end

   assign reg_rdata = reg_rdata_r;

   // analog routing
   assign low_ref_from_pin  = port_cfg_r[`ADSQ_BIT_VREFLO];
   assign high_ref_from_pin = port_cfg_r[`ADSQ_BIT_VREFHI];
   assign sample_channel    = channel_select_r;
   // holding cap on the pin only while sampling; open through the post wait
   assign sample_switch_closed = converter_power_on_r
                              && (state_r == ADSQ_SAMPLE || state_r == ADSQ_DELAY
                              || state_r == ADSQ_ACQUIRE);

   // code c leaves channels below 15-c analog; codes 0..2 keep all thirteen
   // a plain compare instead of a table, so all sixteen codes share one path
   genvar gi;
   generate
      for (gi = 0; gi < 13; gi = gi + 1) begin : g_pin
         assign pin_analog_en[gi] = {1'b0, port_cfg_r[3:0]} < 5'(15 - gi);
      end
   endgenerate

   assign converter_irq_flag = irq_flag_r;
   assign converter_irq      = irq_flag_r && irq_en_r;
endmodule : adsq_core
`default_nettype wire

//--- logic/adsq_map.svh
// Function
// - low reference from pin when bit5 set
// - high reference from pin when bit4 set
// - pin map code turns channels digital downward
// - justify bit 7 set means right justified
// - acquisition code selects 0 to 20 periods
// - clock code selects divider or rc clock
// - rc clock starts one instruction cycle late
// - rc clock lets conversion run in sleep
// - reset clears registers and aborts conversion
// - completion loads result, clears start, sets flag
// - zero acquisition starts conversion at once
// - nonzero acquisition samples then converts automatically
// - after conversion sampling resumes by itself
// - start bit stays set through both phases
// - conversion takes eleven bit periods
// - wait two bit periods before next acquisition
// - one result bit decided per bit period
// - hold capacitor disconnected during conversion
// - clearing start aborts, result kept
// - channel select code routes channel 0 to 12
`ifndef ADSQ_MAP_SVH
`define ADSQ_MAP_SVH
`define ADSQ_OFS_MAIN      3'h0
`define ADSQ_OFS_PORT      3'h1
`define ADSQ_OFS_TIMING    3'h2
`define ADSQ_OFS_RES_HI    3'h3
`define ADSQ_OFS_RES_LO    3'h4
`define ADSQ_OFS_FLAGS     3'h5
`define ADSQ_MAIN_RST      8'h00
`define ADSQ_PORT_RST      8'h00
`define ADSQ_TIMING_RST    8'h00
`define ADSQ_BIT_ON        0
`define ADSQ_BIT_GO        1
`define ADSQ_BIT_CHS_LO    2
`define ADSQ_BIT_VREFLO    5
`define ADSQ_BIT_VREFHI    4
`define ADSQ_BIT_JUSTIFY   7
`define ADSQ_BIT_ACQ_LO    3
`define ADSQ_BIT_IRQF      0
`define ADSQ_BIT_IRQE      1
`define ADSQ_CONV_TADS     4'd11
`define ADSQ_WAIT_TADS     4'd2
`define ADSQ_CLK_NS        100
`define ADSQ_TCY_NS        400
`define ADSQ_TCY_CYC       (((`ADSQ_TCY_NS) + (`ADSQ_CLK_NS) - 1) / (`ADSQ_CLK_NS))
`endif

//--- logic/adsq_pkg.sv
`default_nettype none
package adsq_pkg;
   typedef enum logic [4:0] {
      ADSQ_SAMPLE  = 5'h01,
      ADSQ_DELAY   = 5'h02,
      ADSQ_ACQUIRE = 5'h04,
      ADSQ_CONVERT = 5'h08,
      ADSQ_WAIT    = 5'h10
   } adsq_state_t;
endpackage : adsq_pkg
`default_nettype wire

//--- logic/adsq_tad_gen.sv
`timescale 1ns/1ps
`default_nettype none
module adsq_tad_gen (
   input  wire logic       core_clk,
   input  wire logic       reset,
   input  wire logic       run,
   input  wire logic [2:0] sel,
   input  wire logic       rc_tick,
   output logic            tick
);
   logic [5:0] cnt_r;
   logic [5:0] lim;

   // bit period less one, in oscillator periods, per clock code
   always_comb begin
      case (sel)
         3'h0:    lim = 6'h01;
         3'h4:    lim = 6'h03;
         3'h1:    lim = 6'h07;
         3'h5:    lim = 6'h0f;
         3'h2:    lim = 6'h1f;
         3'h6:    lim = 6'h3f;
         default: lim = 6'h00;
      endcase
   end

   // divider restarts when idle, so a phase begins aligned unless an abort or the rc clock starts it mid-period
   always_ff @(posedge core_clk) begin
      if (reset || !run || sel[1:0] == 2'h3) begin
         cnt_r <= 6'h00;
      end else if (cnt_r == lim) begin
         cnt_r <= 6'h00;
      end else begin
         cnt_r <= cnt_r + 6'h01;
      end
   end

   assign tick = run && ((sel[1:0] == 2'h3) ? rc_tick : (cnt_r == lim));
endmodule : adsq_tad_gen
`default_nettype wire

//--- tb/adsq_core_checker.sv
`timescale 1ns/1ps
`default_nettype none
module adsq_core_checker (
   input wire logic        core_clk,
   input wire logic        reset,
   input wire logic [2:0]  reg_addr,
   input wire logic [7:0]  reg_wdata,
   input wire logic        reg_wr,
   input wire logic        reg_rd,
   input wire logic [7:0]  reg_rdata,
   input wire logic [3:0]  sample_channel,
   input wire logic        sample_switch_closed,
   input wire logic        low_ref_from_pin,
   input wire logic        high_ref_from_pin,
   input wire logic [12:0] pin_analog_en,
   input wire logic        converter_irq_flag
);
   // codes up to 2 keep every channel analog
   function automatic logic [12:0] amask(input logic [3:0] c);
      return (c <= 4'h2) ? 13'h1fff : 13'h1fff >> (c - 4'h2);
   endfunction : amask
   // port config write strobe
   wire logic pw = reg_wr && reg_addr == 3'h1;
   a_low_ref_map: assert property (@(posedge core_clk) disable iff (reset)
      pw |=> low_ref_from_pin == $past(reg_wdata[5])) else $error("low ref wrong");
   a_high_ref_map: assert property (@(posedge core_clk) disable iff (reset)
      pw |=> high_ref_from_pin == $past(reg_wdata[4])) else $error("high ref wrong");
   a_pin_map: assert property (@(posedge core_clk) disable iff (reset)
      pw |=> pin_analog_en == amask($past(reg_wdata[3:0]))) else $error("pin map wrong");
   a_chan_route: assert property (@(posedge core_clk) disable iff (reset)
      reg_wr && reg_addr == 3'h0 |=> sample_channel == $past(reg_wdata[5:2]))
      else $error("channel wrong");
   // no disable here: the reset itself is the cause
   a_reset_state: assert property (@(posedge core_clk) reset |=>
      pin_analog_en == 13'h1fff && !converter_irq_flag && !sample_switch_closed)
      else $error("reset state wrong");
   // conversion is at least 11 periods of 2 clocks, switch stays open
   a_hold_open: assert property (@(posedge core_clk) disable iff (reset)
      $fell(sample_switch_closed) |-> !sample_switch_closed [*8]) else $error("hold reopened");
   a_post_wait: assert property (@(posedge core_clk) disable iff (reset)
      $rose(converter_irq_flag) |-> !sample_switch_closed [*3]) else $error("no post wait");
   a_rd_idle: assert property (@(posedge core_clk) disable iff (reset)
      !reg_rd |=> reg_rdata == 8'h00) else $error("read data not idle");
endmodule : adsq_core_checker
bind adsq_core adsq_core_checker chk (.core_clk(core_clk), .reset(reset),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_rdata(reg_rdata), .sample_channel(sample_channel),
   .sample_switch_closed(sample_switch_closed), .low_ref_from_pin(low_ref_from_pin),
   .high_ref_from_pin(high_ref_from_pin), .pin_analog_en(pin_analog_en),
   .converter_irq_flag(converter_irq_flag));
`default_nettype wire

//--- tb/adsq_core_tb.sv
`timescale 1ns/1ps
`default_nettype none
module adsq_core_tb;
   logic        core_clk, reset, reg_wr, reg_rd, rc_tick, comp_in, sw;
   logic [2:0]  reg_addr;
   logic [7:0]  reg_wdata, reg_rdata, v;
   logic [3:0]  sample_channel;
   logic        sample_switch_closed, low_ref_from_pin, high_ref_from_pin;
   logic [12:0] pin_analog_en;
   logic [9:0]  dac_code, target;
   logic        converter_irq_flag, converter_irq;
   logic [1:0]  rc_cnt;
   logic [15:0] last_res;
   int          errors, compares;
   int          acq_tab [8] = '{0, 2, 4, 6, 8, 12, 16, 20};
   logic [2:0]  cs_tab [7] = '{3'h0, 3'h4, 3'h1, 3'h5, 3'h2, 3'h6, 3'h7};

   adsq_core dut (.core_clk(core_clk), .reset(reset), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .rc_tick(rc_tick), .comp_in(comp_in), .sample_channel(sample_channel),
      .sample_switch_closed(sample_switch_closed), .low_ref_from_pin(low_ref_from_pin),
      .high_ref_from_pin(high_ref_from_pin), .pin_analog_en(pin_analog_en),
      .dac_code(dac_code), .converter_irq_flag(converter_irq_flag),
      .converter_irq(converter_irq));

   // 100 ns clock
   initial begin
      core_clk = 1'b0;
      forever #50 core_clk = ~core_clk;
   end
   // rc ticks every 4 clocks; comparator lags one clock, fine as a period is 2+
   always @(posedge core_clk) begin
      rc_cnt  <= rc_cnt + 2'd1;
      rc_tick <= rc_cnt == 2'd3;
      comp_in <= target >= dac_code;
   end

   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
      compares++;
      if (s !== e) begin
         errors++;
         $display("unexpected %s expected %h seen %h", n, e, s);
      end
   endtask : chk
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
      @(posedge core_clk);
   endtask : wr
   // data stand only in the cycle after the strobe
   task automatic rd(input logic [2:0] a, output logic [7:0] d);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
      sw = sample_switch_closed;
      @(posedge core_clk);
   endtask : rd
   task automatic close_out;
      $display("errors %0d compares %0d", errors, compares);
      if (errors == 0 && compares > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : close_out

   task automatic t_regs;
      for (int a = 0; a < 8; a++) begin
         rd(a[2:0], v);
         chk("reg_reset", 16'h0, v);
      end
      chk("pins_reset", 16'h1fff, pin_analog_en);
   endtask : t_regs
   task automatic t_port;
      logic [7:0] d;
      for (int c = 0; c < 16; c++) begin
         d = {c[1:0], c[0], ~c[0], c[3:0]};
         wr(3'h1, d);
         rd(3'h1, v);
         chk("port_reg", d & 8'h3f, v);
         chk("pin_map", c <= 2 ? 16'h1fff : 16'h1fff >> (c - 2), pin_analog_en);
         chk("low_ref", d[5], low_ref_from_pin);
         chk("high_ref", d[4], high_ref_from_pin);
      end
   endtask : t_port
   task automatic t_conv(input logic [2:0] acq, input logic [2:0] cs, input logic [9:0] t,
                         input logic rj);
      int n, ex, dv;
      dv = (cs == 3'h7) ? 4 : 2 << ({cs[1:0], 1'b0} + cs[2]);
      ex = (acq_tab[acq] + 11) * dv + ((cs == 3'h7) ? 4 : 0);
      target = t;
      wr(3'h5, 8'h02);
      wr(3'h2, {rj, 1'b0, acq, cs});
      wr(3'h0, 8'h1d);
      wr(3'h0, 8'h1f);
      rd(3'h0, v);
      chk("go_busy", 16'h1f, v);
      if (cs != 3'h7) chk("sampling", acq != 3'h0, sw);
      chk("channel", 16'h7, sample_channel);
      n = 3;
      while (converter_irq_flag !== 1'b1 && n < 4000) begin
         @(posedge core_clk);
         #1 n++;
      end
      chk("conv_time", 1, n >= ex - 2 && n <= ex + dv + 8);
      chk("irq", 1, converter_irq);
      @(posedge core_clk);
      rd(3'h0, v);
      chk("go_done", 16'h1d, v);
      last_res = rj ? {6'h00, t} : {t, 6'h00};
      rd(3'h3, v);
      chk("res_hi", last_res[15:8], v);
      rd(3'h4, v);
      chk("res_lo", last_res[7:0], v);
      repeat (2 * dv + 4) @(posedge core_clk);
      #1 chk("resample", 1, sample_switch_closed);
      @(posedge core_clk);
   endtask : t_conv
   // slow clock so the abort lands mid conversion
   task automatic t_abort;
      wr(3'h5, 8'h00);
      target = 10'h155;
      wr(3'h2, 8'h06);
      wr(3'h0, 8'h1f);
      repeat (100) @(posedge core_clk);
      wr(3'h0, 8'h1d);
      rd(3'h5, v);
      chk("abort_flag", 16'h0, v);
      rd(3'h3, v);
      chk("abort_hi", last_res[15:8], v);
      rd(3'h4, v);
      chk("abort_lo", last_res[7:0], v);
      repeat (60) @(posedge core_clk);
      #1 chk("abort_wait", 0, sample_switch_closed);
      repeat (200) @(posedge core_clk);
      #1 chk("abort_resample", 1, sample_switch_closed);
      @(posedge core_clk);
   endtask : t_abort
   task automatic t_rst_mid;
      wr(3'h0, 8'h1f);
      repeat (50) @(posedge core_clk);
      reset <= 1'b1;
      repeat (2) @(posedge core_clk);
      reset <= 1'b0;
      @(posedge core_clk);
      rd(3'h0, v);
      chk("rst_main", 16'h0, v);
      rd(3'h2, v);
      chk("rst_timing", 16'h0, v);
      repeat (800) @(posedge core_clk);
      #1 chk("rst_no_done", 0, converter_irq_flag);
      @(posedge core_clk);
      wr(3'h0, 8'h02);
      rd(3'h0, v);
      chk("go_unpowered", 16'h0, v);
   endtask : t_rst_mid

   initial begin
      {reset, reg_wr, reg_rd, reg_addr, reg_wdata, rc_cnt, rc_tick, comp_in} = 18'h20000;
      {target, last_res, errors, compares} = '0;
      repeat (8) @(posedge core_clk);
      reset <= 1'b0;
      @(posedge core_clk);
      t_regs();
      t_port();
      // 8 oscillator periods is the shortest legal bit period at this clock
      for (int i = 0; i < 8; i++) begin
         t_conv(i[2:0], 3'h1, 10'h2a5 ^ 10'(i * 37), i[0]);
      end
      for (int i = 0; i < 7; i++) t_conv(3'h1, cs_tab[i], 10'(i * 101 + 3), i[0]);
      t_abort();
      t_rst_mid();
      close_out();
   end
   // run needs about 5000 clocks
   initial begin
      repeat (20000) @(posedge core_clk);
      errors++;
      close_out();
   end
endmodule : adsq_core_tb
`default_nettype wire
